// >>> rtl/pll_cfg_regs.svh
// offsets, field positions, reset values and timing counts of the pll configuration group
// assumes inclusion by the top module only
`ifndef PLL_CFG_REGS_SVH
`define PLL_CFG_REGS_SVH
`define OFS_ZERO_HIGH 8'h00
`define OFS_ZERO_LOW 8'h01
`define OFS_ONE_HIGH 8'h02
`define OFS_ONE_LOW 8'h03
`define OFS_RADIO_CTRL_TWO 8'h04
`define OFS_RADIO_CTRL_SEVEN 8'h05
`define BIT_INVERT_DATA 2
`define BIT_BAND_SELECT 2
`define BIT_KEYING_SELECT 1
`define BIT_REF_OUT_ENABLE 0
`define BIT_PAGE_SELECT 0
`define BIT_SOFT_RESET 0
`define RST_DIVIDER_WORD 13'h0000
`define RST_CODING 2'h0
`define FRAC_DENOM 8192
`define BASE_INT_LOW 12
`define BASE_INT_STEP 4
`define REF_FREQ_KHZ 500
`define XTAL_FREQ_KHZ 26000
`endif

// >>> rtl/pll_cfg_pkg.sv
// types shared by the pll configuration group
// assumes the register header alongside
package pll_cfg_pkg;
   typedef enum logic [1:0]
   {
      CODE_MANCHESTER = 2'b00,
      CODE_BIPHASE = 2'b01,
      CODE_NRZ = 2'b10,
      CODE_DIRECT = 2'b11
   } coding_e;
   typedef logic [12:0] divword_t;
endpackage

// >>> rtl/pll_cfg_block.sv
// pll configuration registers of the radio transmitter, with page gating and soft reset
// assumes a plain one-cycle strobe register port on MCLK and an analog synthesizer outside
//
// How it works
// - pll registers reachable only while page select is clear; else read zero, writes ignored
// - zero word bits 12:5 in first register, bits 4:0 in second register bits 7:3
// - fsk zero carrier is crystal times integer part plus zero word over 8192
// - soft reset clears the whole zero divider word
// - one word bits 12:5 in third register, bits 4:0 in fourth bits 7:3
// - one carrier is crystal times integer part plus one word over 8192
// - soft reset clears the whole one divider word
// - bit 2 of second register inverts data and flips coded polarity; reset clears
// - coding field picks manchester, bi-phase, nrz from buffer, or direct processor bit
// - soft reset clears the coding field to manchester from buffer
// - band bit picks 315 or 434 mhz vco setup; soft reset clears it
// - band bit picks the divider making a 500 khz reference in either band
// - keying bit picks ook when 0 and fsk when 1; soft reset clears it
// - reference enable gates the 500 khz reference to the general timer module
// - writing one to soft reset reinitialises the radio; reads zero; cpu reset leaves it
// - page select lives in radio control register two
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "pll_cfg_regs.svh"
module pll_cfg_block
   import pll_cfg_pkg::*;
#(
   parameter int XTAL_KHZ = `XTAL_FREQ_KHZ,
   parameter int REF_KHZ = `REF_FREQ_KHZ
)
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // register port
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // data path from the rest of the radio
   input wire logic BUF_BIT,
   input wire logic CPU_DATA_BIT,
   // synthesizer controls
   output logic [4:0] PLL_INT,
   output logic [12:0] PLL_FRAC,
   output logic CARRIER_ON,
   output logic BAND_SELECT,
   output logic KEYING_SELECT,
   output logic [1:0] CODING,
   output logic INVERT_DATA,
   output logic DIRECT_MODE,
   output logic REGISTER_PAGE_SELECT,
   // reference clock to the timer
   output logic TIMER_REFERENCE_CLOCK
);
   // divider counts for the reference; one crystal serves both bands, so both counts match
   localparam int REF_DIV_HALF = XTAL_KHZ / (2 * REF_KHZ);
   localparam int REF_DIV_HALF_HI = XTAL_KHZ / (2 * REF_KHZ);
   if (REF_DIV_HALF < 1 || REF_DIV_HALF > 255 || REF_DIV_HALF_HI < 1 || REF_DIV_HALF_HI > 255)
   begin : g_ref_range
      $error("reference divider out of range");
   end

   divword_t zero_word_r;
   divword_t one_word_r;
   logic invert_r;
   logic direct_r;
   coding_e coding_r;
   logic band_r;
   logic keying_r;
   logic refen_r;
   logic page_r;
   logic [7:0] rdata_r;
   logic [7:0] refcnt_r;
   logic [7:0] refcnt_nxt;
   logic ref_r;
   logic symbol_r;
   logic [4:0] pll_int_r;
   logic [12:0] pll_frac_r;
   logic carrier_r;

   // decode
   wire pll_vis = ~page_r;
   wire wr_zh = WR && ADDR == `OFS_ZERO_HIGH && pll_vis;
   wire wr_zl = WR && ADDR == `OFS_ZERO_LOW && pll_vis;
   wire wr_oh = WR && ADDR == `OFS_ONE_HIGH && pll_vis;
   wire wr_ol = WR && ADDR == `OFS_ONE_LOW && pll_vis;
   wire wr_c2 = WR && ADDR == `OFS_RADIO_CTRL_TWO;
   wire soft_rst = WR && ADDR == `OFS_RADIO_CTRL_SEVEN && WDATA[`BIT_SOFT_RESET];
   wire clr = RST || soft_rst;

   // read mux; pll registers read zero while the other page is selected
   wire [7:0] rd_zh = pll_vis ? zero_word_r[12:5] : 8'h00;
   wire [7:0] rd_zl = pll_vis ? {zero_word_r[4:0], invert_r, coding_r} : 8'h00;
   wire [7:0] rd_oh = pll_vis ? one_word_r[12:5] : 8'h00;
   wire [7:0] rd_ol = pll_vis ? {one_word_r[4:0], band_r, keying_r, refen_r} : 8'h00;
   wire [7:0] rd_c2 = {7'h00, page_r};
   wire [7:0] rd_mux =
      ADDR == `OFS_ZERO_HIGH ? rd_zh :
      ADDR == `OFS_ZERO_LOW ? rd_zl :
      ADDR == `OFS_ONE_HIGH ? rd_oh :
      ADDR == `OFS_ONE_LOW ? rd_ol :
      ADDR == `OFS_RADIO_CTRL_TWO ? rd_c2 : 8'h00; // soft reset bit reads zero

   // zero word, polarity and coding
   always_ff @(posedge MCLK)
   begin
      if (clr)
      begin
         zero_word_r <= `RST_DIVIDER_WORD;
         invert_r <= 1'b0;
         coding_r <= CODE_MANCHESTER;
         direct_r <= 1'b0;
      end
      else
      begin
         if (wr_zh)
            zero_word_r[12:5] <= WDATA;
         if (wr_zl)
         begin
            zero_word_r[4:0] <= WDATA[7:3];
            invert_r <= WDATA[`BIT_INVERT_DATA];
            coding_r <= coding_e'(WDATA[1:0]);
            direct_r <= WDATA[1:0] == 2'h3;
         end
      end
   end

   // one word, band and keying
   always_ff @(posedge MCLK)
   begin
      if (clr)
      begin
         one_word_r <= `RST_DIVIDER_WORD;
         band_r <= 1'b0;
         keying_r <= 1'b0;
      end
      else
      begin
         if (wr_oh)
            one_word_r[12:5] <= WDATA;
         if (wr_ol)
         begin
            one_word_r[4:0] <= WDATA[7:3];
            band_r <= WDATA[`BIT_BAND_SELECT];
            keying_r <= WDATA[`BIT_KEYING_SELECT];
         end
      end
   end

   // reference enable survives soft reset; page select in control two
   always_ff @(posedge MCLK)
   begin
      if (RST)
         refen_r <= 1'b0;
      else if (wr_ol)
         refen_r <= WDATA[`BIT_REF_OUT_ENABLE];
   end

   always_ff @(posedge MCLK)
   begin
      if (clr)
         page_r <= 1'b0;
      else if (wr_c2)
         page_r <= WDATA[`BIT_PAGE_SELECT];
   end

   always_ff @(posedge MCLK)
   begin
      if (RST)
         rdata_r <= 8'h00;
      else if (RD)
         rdata_r <= rd_mux;
      else
         rdata_r <= 8'h00;
   end

   // reference divider, half period chosen by band
   wire [7:0] half_cnt = band_r ? 8'(REF_DIV_HALF_HI) : 8'(REF_DIV_HALF);
   wire ref_wrap = refcnt_r >= half_cnt - 8'h01;
   assign refcnt_nxt = ref_wrap ? 8'h00 : refcnt_r + 8'h01;
   always_ff @(posedge MCLK)
   begin
      if (RST || !refen_r)
      begin
         refcnt_r <= 8'h00;
         ref_r <= 1'b0;
      end
      else
      begin
         refcnt_r <= refcnt_nxt;
         if (ref_wrap)
            ref_r <= ~ref_r;
      end
   end

   // symbol selection and synthesizer word
   wire raw_bit = (coding_r == CODE_DIRECT) ? CPU_DATA_BIT : BUF_BIT;
   wire sym = raw_bit ^ invert_r;
   wire [4:0] int_part = band_r ? 5'(`BASE_INT_LOW + `BASE_INT_STEP) : 5'(`BASE_INT_LOW);
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         symbol_r <= 1'b0;
         pll_int_r <= 5'(`BASE_INT_LOW);
         pll_frac_r <= 13'h0000;
         carrier_r <= 1'b0;
      end
      else
      begin
         symbol_r <= sym;
         pll_int_r <= int_part;
         pll_frac_r <= (sym || !keying_r) ? one_word_r : zero_word_r;
         carrier_r <= sym || keying_r;
      end
   end

   assign RDATA = rdata_r;
   assign PLL_INT = pll_int_r;
   assign PLL_FRAC = pll_frac_r;
   assign CARRIER_ON = carrier_r;
   assign BAND_SELECT = band_r;
   assign KEYING_SELECT = keying_r;
   assign CODING = coding_r;
   assign INVERT_DATA = invert_r;
   assign DIRECT_MODE = direct_r;
   assign REGISTER_PAGE_SELECT = page_r;
   assign TIMER_REFERENCE_CLOCK = ref_r;

   // checks
   chk_soft_clears: assert property (@(posedge MCLK) disable iff (RST)
      soft_rst |=> zero_word_r == 13'h0000 && one_word_r == 13'h0000
      && coding_r == CODE_MANCHESTER && !band_r && !keying_r && !invert_r)
      else $error("soft reset left a field set");
   chk_coding_reset: assert property (@(posedge MCLK) disable iff (RST)
      soft_rst |=> CODING == 2'h0 && !DIRECT_MODE)
      else $error("soft reset left coding set");
   chk_page_hides: assert property (@(posedge MCLK) disable iff (RST)
      RD && page_r && ADDR <= `OFS_ONE_LOW |=> RDATA == 8'h00)
      else $error("pll field visible on other page");
   chk_page_blocks: assert property (@(posedge MCLK) disable iff (RST)
      WR && page_r && ADDR <= `OFS_ONE_LOW |=> $stable(zero_word_r) && $stable(one_word_r)
      && $stable(coding_r) && $stable(invert_r) && $stable(band_r) && $stable(keying_r))
      else $error("pll field written on other page");
   chk_split_zero: assert property (@(posedge MCLK) disable iff (RST)
      wr_zh && !soft_rst |=> zero_word_r[12:5] == $past(WDATA))
      else $error("zero word high not stored");
   chk_split_low_zero: assert property (@(posedge MCLK) disable iff (RST)
      wr_zl |=> zero_word_r[4:0] == $past(WDATA[7:3])
      && invert_r == $past(WDATA[`BIT_INVERT_DATA]))
      else $error("zero word low not stored");
   chk_split_high_one: assert property (@(posedge MCLK) disable iff (RST)
      wr_oh |=> one_word_r[12:5] == $past(WDATA))
      else $error("one word high not stored");
   chk_split_one: assert property (@(posedge MCLK) disable iff (RST)
      wr_ol && !soft_rst |=> one_word_r[4:0] == $past(WDATA[7:3]))
      else $error("one word low not stored");
   chk_mode_store: assert property (@(posedge MCLK) disable iff (RST)
      wr_ol |=> band_r == $past(WDATA[`BIT_BAND_SELECT])
      && keying_r == $past(WDATA[`BIT_KEYING_SELECT]))
      else $error("band or keying not stored");
   chk_ook_off: assert property (@(posedge MCLK) disable iff (RST)
      !keying_r && !sym |=> !CARRIER_ON)
      else $error("carrier on for ook zero");
   chk_ook_word: assert property (@(posedge MCLK) disable iff (RST)
      !keying_r |=> PLL_FRAC == $past(one_word_r))
      else $error("ook used the zero word");
   chk_fsk_zero: assert property (@(posedge MCLK) disable iff (RST)
      keying_r && !sym |=> PLL_FRAC == $past(zero_word_r) && CARRIER_ON)
      else $error("fsk zero word wrong");
   chk_one_word: assert property (@(posedge MCLK) disable iff (RST)
      sym |=> PLL_FRAC == $past(one_word_r) && PLL_INT == $past(int_part))
      else $error("one word wrong");
   chk_band_low: assert property (@(posedge MCLK) disable iff (RST)
      !band_r |=> PLL_INT == 5'h0C)
      else $error("low band integer wrong");
   chk_band_high: assert property (@(posedge MCLK) disable iff (RST)
      band_r |=> PLL_INT == 5'h10)
      else $error("high band integer wrong");
   chk_ref_gate: assert property (@(posedge MCLK) disable iff (RST)
      !refen_r |=> !TIMER_REFERENCE_CLOCK)
      else $error("reference out while disabled");
   chk_ref_toggle: assert property (@(posedge MCLK) disable iff (RST)
      refen_r && ref_wrap |=> TIMER_REFERENCE_CLOCK != $past(TIMER_REFERENCE_CLOCK))
      else $error("reference missed its toggle");
   chk_ref_hold: assert property (@(posedge MCLK) disable iff (RST)
      refen_r && !ref_wrap |=> $stable(TIMER_REFERENCE_CLOCK))
      else $error("reference toggled early");
   chk_ref_survives: assert property (@(posedge MCLK) disable iff (RST)
      soft_rst && refen_r |=> refen_r)
      else $error("soft reset cleared reference enable");
   chk_page_cleared: assert property (@(posedge MCLK) disable iff (RST)
      soft_rst |=> !REGISTER_PAGE_SELECT)
      else $error("soft reset left page select set");
   chk_page_reads: assert property (@(posedge MCLK) disable iff (RST)
      RD && ADDR == `OFS_RADIO_CTRL_TWO |=> RDATA == {7'h00, $past(page_r)})
      else $error("page select read wrong");
   chk_soft_reads: assert property (@(posedge MCLK) disable iff (RST)
      RD && ADDR == `OFS_RADIO_CTRL_SEVEN |=> RDATA == 8'h00)
      else $error("soft reset bit read nonzero");
   chk_direct_cpu: assert property (@(posedge MCLK) disable iff (RST)
      keying_r && coding_r == CODE_DIRECT && (CPU_DATA_BIT ^ invert_r)
      |=> PLL_FRAC == $past(one_word_r))
      else $error("direct mode source wrong");
   chk_buffer_src: assert property (@(posedge MCLK) disable iff (RST)
      keying_r && coding_r != CODE_DIRECT && !(BUF_BIT ^ invert_r)
      |=> PLL_FRAC == $past(zero_word_r))
      else $error("buffer source wrong");
endmodule

// >>> verification/synth_model.sv
// synthesizer model: turns the divider outputs into a carrier frequency in khz
// assumes the block's integer, fraction and carrier-on outputs, all registered
`timescale 1ns/100ps
module synth_model
#(
   parameter int XTAL_KHZ = 26000
)
(
   // divider controls
   input wire logic [4:0] pll_int,
   input wire logic [12:0] pll_frac,
   input wire logic carrier_on,
   // resulting carrier, zero while keyed off
   output logic [31:0] carrier_khz
);
   logic [63:0] prod;
   assign prod = 64'(XTAL_KHZ) * (64'({pll_int, 13'h0000}) + 64'(pll_frac));
   assign carrier_khz = carrier_on ? prod[44:13] : 32'h0000_0000;
endmodule

// >>> verification/pll_cfg_block_tb.sv
// self-checking bench for the pll configuration registers
// assumes the one-cycle strobe register port and the synthesizer model beside it
`timescale 1ns/100ps
module pll_cfg_block_tb;
   import pll_cfg_pkg::*;
   logic MCLK = 1'b0;
   logic RST = 1'b1;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic BUF_BIT = 1'b0;
   logic CPU_DATA_BIT = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [7:0] WDATA = 8'h00;
   logic [7:0] RDATA;
   logic [4:0] PLL_INT;
   logic [12:0] PLL_FRAC;
   logic [1:0] CODING;
   logic CARRIER_ON, BAND_SELECT, KEYING_SELECT, INVERT_DATA, DIRECT_MODE;
   logic REGISTER_PAGE_SELECT, TIMER_REFERENCE_CLOCK;
   logic [31:0] carrier_khz;
   int n_errors = 0;
   int n_compared = 0;
   // 26 MHz crystal ticks per half period of the 500 kHz reference
   localparam int REF_HALF = 26000 / (2 * 500);
   pll_cfg_block u_pll_cfg_block (.MCLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .BUF_BIT,
      .CPU_DATA_BIT, .PLL_INT, .PLL_FRAC, .CARRIER_ON, .BAND_SELECT, .KEYING_SELECT, .CODING,
      .INVERT_DATA, .DIRECT_MODE, .REGISTER_PAGE_SELECT, .TIMER_REFERENCE_CLOCK);
   synth_model u_synth_model (.pll_int(PLL_INT), .pll_frac(PLL_FRAC),
      .carrier_on(CARRIER_ON), .carrier_khz(carrier_khz));
   always #12.5 MCLK = ~MCLK;
   function automatic logic [31:0] khz(input logic [63:0] n, input logic [63:0] w);
      logic [63:0] p;
      p = (64'd26000 * (n * 64'd8192 + w)) / 64'd8192;
      return p[31:0];
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge MCLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask
   task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
      @(posedge MCLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 chk("read data", {24'h0, exp}, {24'h0, RDATA});
   endtask
   task automatic drive(input logic b, input logic c);
      @(posedge MCLK);
      BUF_BIT <= b;
      CPU_DATA_BIT <= c;
      @(posedge MCLK);
      #1;
   endtask
   task automatic ref_half(input string what);
      int n;
      int w;
      logic last;
      n = 0;
      w = 0;
      @(posedge MCLK);
      #1 last = TIMER_REFERENCE_CLOCK;
      while (TIMER_REFERENCE_CLOCK === last && w < 200)
      begin
         @(posedge MCLK);
         #1 w++;
      end
      last = TIMER_REFERENCE_CLOCK;
      while (TIMER_REFERENCE_CLOCK === last && n < 200)
      begin
         @(posedge MCLK);
         #1 n++;
      end
      chk(what, REF_HALF, n);
   endtask
   task automatic finish_test;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic test_reset;
      #1 chk("integer", 32'hC, PLL_INT);
      chk("fraction", 32'h0, PLL_FRAC);
      chk("coding", 32'h0, CODING);
      rd_check(8'h00, 8'h00);
      rd_check(8'h03, 8'h00);
      $display("test reset done");
   endtask
   task automatic test_words;
      wr(8'h00, 8'hAB);
      wr(8'h01, 8'h98);
      wr(8'h02, 8'h5C);
      wr(8'h03, 8'h27);
      rd_check(8'h00, 8'hAB);
      rd_check(8'h01, 8'h98);
      rd_check(8'h02, 8'h5C);
      rd_check(8'h03, 8'h27);
      chk("band", 32'h1, BAND_SELECT);
      chk("keying", 32'h1, KEYING_SELECT);
      chk("integer", 32'h10, PLL_INT);
      drive(1'b0, 1'b0);
      chk("fraction", 32'h1573, PLL_FRAC);
      chk("carrier", khz(16, 'h1573), carrier_khz);
      drive(1'b1, 1'b0);
      chk("fraction", 32'hB84, PLL_FRAC);
      chk("carrier", khz(16, 'hB84), carrier_khz);
      wr(8'h01, 8'h9C);
      drive(1'b0, 1'b0);
      chk("fraction", 32'hB84, PLL_FRAC);
      chk("invert", 32'h1, INVERT_DATA);
      wr(8'h01, 8'h98);
      wr(8'h03, 8'h25);
      drive(1'b0, 1'b0);
      chk("carrier on", 32'h0, CARRIER_ON);
      chk("fraction", 32'hB84, PLL_FRAC);
      $display("test words done");
   endtask
   task automatic test_coding;
      wr(8'h03, 8'h27);
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h01, {6'b100110, 2'(c)});
         drive(1'b0, 1'b1);
         chk("coding", 32'(c), CODING);
         chk("direct", 32'(c == 3), DIRECT_MODE);
         chk("fraction", (c == 3) ? 32'hB84 : 32'h1573, PLL_FRAC);
      end
      wr(8'h01, 8'h9A);
      drive(1'b1, 1'b0);
      chk("nrz first half", 32'hB84, PLL_FRAC);
      drive(1'b0, 1'b0);
      chk("nrz second half", 32'h1573, PLL_FRAC);
      $display("test coding done");
   endtask
   task automatic test_page_and_reset;
      wr(8'h04, 8'h01);
      #1 chk("page", 32'h1, REGISTER_PAGE_SELECT);
      wr(8'h00, 8'hFF);
      rd_check(8'h00, 8'h00);
      wr(8'h04, 8'h00);
      rd_check(8'h00, 8'hAB);
      rd_check(8'h10, 8'h00);
      ref_half("reference half period band one");
      wr(8'h03, 8'h23);
      ref_half("reference half period band zero");
      wr(8'h03, 8'h26);
      repeat (60) @(posedge MCLK);
      #1 chk("reference off", 32'h0, TIMER_REFERENCE_CLOCK);
      wr(8'h03, 8'h27);
      wr(8'h05, 8'h01);
      rd_check(8'h00, 8'h00);
      rd_check(8'h03, 8'h01);
      rd_check(8'h05, 8'h00);
      chk("integer", 32'hC, PLL_INT);
      chk("coding", 32'h0, CODING);
      chk("page", 32'h0, REGISTER_PAGE_SELECT);
      $display("test page and soft reset done");
   endtask
   initial
   begin
      repeat (20000) @(posedge MCLK);
      n_errors++;
      finish_test();
   end
   initial
   begin
      repeat (5) @(posedge MCLK);
      RST <= 1'b0;
      @(posedge MCLK);
      test_reset();
      test_words();
      test_coding();
      test_page_and_reset();
      finish_test();
   end
endmodule
